/* inc/gradient_map.vh */
`ifndef GRADIENT_MAP_VH
`define GRADIENT_MAP_VH
// Register byte offsets
`define OFS_DEPTH_STEP_X_FIXED 12'h000
`define OFS_DEPTH_STEP_X_FLOAT 12'h004
`define OFS_TEXS_STEP_X_FIXED 12'h008
`define OFS_TEXT_STEP_X_FIXED 12'h00C
`define OFS_TEXS_STEP_X_FLOAT 12'h010
`define OFS_TEXT_STEP_X_FLOAT 12'h014
`define OFS_RECIPW_STEP_X_FIXED 12'h018
`define OFS_RECIPW_STEP_X_FLOAT 12'h01C
`define OFS_RED_STEP_Y_FIXED 12'h020
`define OFS_GREEN_STEP_Y_FIXED 12'h024
`define OFS_BLUE_STEP_Y_FIXED 12'h028
`define OFS_ALPHA_STEP_Y_FIXED 12'h02C
`define OFS_RED_STEP_Y_FLOAT 12'h030
`define OFS_GREEN_STEP_Y_FLOAT 12'h034
`define OFS_BLUE_STEP_Y_FLOAT 12'h038
`define OFS_ALPHA_STEP_Y_FLOAT 12'h03C
`define OFS_DEPTH_STEP_Y_FIXED 12'h040
`define OFS_DEPTH_STEP_Y_FLOAT 12'h044
`define OFS_TEXS_STEP_Y_FIXED 12'h048
`define OFS_TEXT_STEP_Y_FIXED 12'h04C
`define OFS_TEXS_STEP_Y_FLOAT 12'h050
`define OFS_TEXT_STEP_Y_FLOAT 12'h054
`define OFS_RECIPW_STEP_Y_FIXED 12'h058
`define OFS_RECIPW_STEP_Y_FLOAT 12'h05C
`define OFS_DRAW_TRIANGLE_FIXED 12'h060
`define OFS_DRAW_TRIANGLE_FLOAT 12'h064
// Own registers: readable state and step control
`define OFS_RASTER_STATUS 12'h080
`define OFS_STEP_CONTROL 12'h084
`define OFS_ACC_SELECT 12'h088
`define OFS_ACC_VALUE 12'h08C
// Fraction bits of each fixed-point format
`define FRAC_DEPTH 12
`define FRAC_TEX 18
`define FRAC_RECIPW 30
`define FRAC_COLOR 12
`define COLOR_MSB 23
`define ORIENT_BIT 31
// Step control fields
`define STEP_X_BIT 0
`define STEP_Y_BIT 1
`define STEP_NEG_BIT 2
`define STEP_DONE_BIT 3
// Accumulator indices
`define ACC_DEPTH 3'h0
`define ACC_TEXS 3'h1
`define ACC_TEXT 3'h2
`define ACC_RECIPW 3'h3
`define ACC_RED 3'h4
`define ACC_GREEN 3'h5
`define ACC_BLUE 3'h6
`define ACC_ALPHA 3'h7
`define GRAD_RESET 32'h0000_0000
`endif

/* logic/triangle_gradient_setup.v */
// Notes on behaviour
// R1: X steps add the X gradient going right, subtract going left.
// R2: Y steps add the Y gradient going up in Y, subtract going down.
// R3: Depth gradients are 32-bit two's complement 20.12.
// R4: Texture S and T gradients are 32-bit two's complement 14.18.
// R5: Reciprocal-W gradients are 32-bit two's complement 2.30.
// R6: Colour Y gradients are 24-bit 12.12 in the low bits.
// R7: Float gradients are converted to the same internal fixed form.
// R8: Host pre-divides S and T gradients by W.
// R9: Any write to either draw command starts one triangle.
// R10: Host loads all triangle registers before the draw command.
// R11: Command bit 31 gives orientation: 0 counter-clockwise, 1 clockwise.
// R12: Command bits 30 to 0 are ignored.
// R13: Host sorts vertices by Y and computes the signed area.
// R14: Host must send a sign matching the vertices, else endless render.
// R15: Host writes a dummy word to nonexistent texture unit 3.
// R16: Host fences writes before and after the draw command.
// R17: Vertex coordinates are 16-bit two's complement 12.4.
// R18: Gradients keep their values across triangles until rewritten.
//
// Decided for this implementation: register access over APB and the register offsets.
`include "gradient_map.vh"
`timescale 1ns/1ns
`default_nettype none
module triangle_gradient_setup (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // Rasterizer stepping
   input wire step_x,
   input wire step_y,
   input wire step_neg,
   input wire raster_done,
   input wire [15:0] vertex_x,
   input wire [15:0] vertex_y,
   // Draw start and accumulators
   output reg draw_start,
   output reg orient_cw,
   output reg busy,
   output reg [31:0] depth_acc,
   output reg [31:0] texs_acc,
   output reg [31:0] text_acc,
   output reg [31:0] recipw_acc,
   output reg [23:0] red_acc,
   output reg [23:0] green_acc,
   output reg [23:0] blue_acc,
   output reg [23:0] alpha_acc,
   output reg [31:0] start_vertex
);

   ////////////////////////////////////////////////////////////////////////
   // IEEE single to signed fixed with given fraction bits; saturates.
   // Denormals flush to zero; NaN and infinity saturate by sign.
   function [31:0] flt2fix;
      input [31:0] f;
      input [5:0] frac;
      reg [8:0] sh;
      reg [55:0] mag;
      reg [31:0] res;
      integer e;
      begin
         sh = 9'h000;
         mag = 56'h00_0000_0000_0000;
         res = 32'h0000_0000;
         e = f[30:23] - 127 + frac - 23;
         if (f[30:23] == 8'h00) begin
            res = 32'h0000_0000;
         end else if (e > 7) begin
            res = f[31] ? 32'h8000_0000 : 32'h7FFF_FFFF;
         end else begin
            if (e >= 0) begin
               sh = e[8:0];
               mag = {32'h0000_0000, 1'b1, f[22:0]} << sh;
            end else if (e > -25) begin
               sh = 9'h000 - e[8:0];
               mag = {32'h0000_0000, 1'b1, f[22:0]} >> sh;
            end
            if (mag[55:31] != 25'h000_0000) begin
               res = f[31] ? 32'h8000_0000 : 32'h7FFF_FFFF;
            end else begin
               res = f[31] ? (~mag[31:0] + 32'h0000_0001) : mag[31:0];
            end
         end
         flt2fix = res;
      end
   endfunction

   // Add or subtract a gradient
   function [31:0] step_val;
      input [31:0] acc;
      input [31:0] grad;
      input neg;
      begin
         step_val = neg ? acc - grad : acc + grad;
      end
   endfunction

   // Colour step, kept to the 24-bit accumulator width
   function [23:0] step_col;
      input [23:0] acc;
      input [23:0] grad;
      input neg;
      reg [31:0] t;
      begin
         t = step_val({8'h00, acc}, {8'h00, grad}, neg);
         step_col = t[23:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Synchronise raster stepping inputs, which arrive from outside
   reg [3:0] step_s1_reg;
   reg [3:0] step_s2_reg;
   reg [3:0] step_d_reg;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_s1_reg <= 4'h0;
         step_s2_reg <= 4'h0;
         step_d_reg <= 4'h0;
      end else begin
         step_s1_reg <= {raster_done, step_neg, step_y, step_x};
         step_s2_reg <= step_s1_reg;
         step_d_reg <= step_s2_reg;
      end
   end
   // Edge detect on the second flop against a third; the first only feeds the second
   wire hw_x = step_s2_reg[0] & ~step_d_reg[0];
   wire hw_y = step_s2_reg[1] & ~step_d_reg[1];
   // Direction is a level, taken as it stands
   wire hw_neg = step_s2_reg[2];
   wire hw_done = step_s2_reg[3] & ~step_d_reg[3];

   ////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states, unmapped address gives error
   wire wr = psel & penable & pwrite;
   wire rd = psel & penable & ~pwrite;
   reg mapped;
   always @* begin
      case (paddr)
         `OFS_RASTER_STATUS: mapped = 1'b1;
         `OFS_STEP_CONTROL: mapped = 1'b1;
         `OFS_ACC_SELECT: mapped = 1'b1;
         `OFS_ACC_VALUE: mapped = 1'b1;
         default: mapped = (paddr <= `OFS_DRAW_TRIANGLE_FLOAT) && (paddr[1:0] == 2'b00);
      endcase
   end
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   ////////////////////////////////////////////////////////////////////////
   // Gradient storage in internal fixed form; kept until rewritten [R18]
   reg [31:0] depth_step_x_fixed_reg;
   reg [31:0] texs_step_x_fixed_reg;
   reg [31:0] text_step_x_fixed_reg;
   reg [31:0] recipw_step_x_fixed_reg;
   reg [31:0] depth_step_y_fixed_reg;
   reg [31:0] texs_step_y_fixed_reg;
   reg [31:0] text_step_y_fixed_reg;
   reg [31:0] recipw_step_y_fixed_reg;
   reg [23:0] red_step_y_fixed_reg;
   reg [23:0] green_step_y_fixed_reg;
   reg [23:0] blue_step_y_fixed_reg;
   reg [23:0] alpha_step_y_fixed_reg;
   reg [2:0] acc_sel_reg;
   wire [31:0] c_fix = flt2fix(pwdata, 6'd`FRAC_COLOR);

   // X gradients
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         depth_step_x_fixed_reg <= `GRAD_RESET;
         texs_step_x_fixed_reg <= `GRAD_RESET;
         text_step_x_fixed_reg <= `GRAD_RESET;
         recipw_step_x_fixed_reg <= `GRAD_RESET;
      end else if (wr) begin
         case (paddr)
            `OFS_DEPTH_STEP_X_FIXED: depth_step_x_fixed_reg <= pwdata; // [R3]
            `OFS_DEPTH_STEP_X_FLOAT: depth_step_x_fixed_reg <= flt2fix(pwdata, 6'd`FRAC_DEPTH); // [R7]
            `OFS_TEXS_STEP_X_FIXED: texs_step_x_fixed_reg <= pwdata; // [R4]
            `OFS_TEXT_STEP_X_FIXED: text_step_x_fixed_reg <= pwdata; // [R4]
            `OFS_TEXS_STEP_X_FLOAT: texs_step_x_fixed_reg <= flt2fix(pwdata, 6'd`FRAC_TEX); // [R7]
            `OFS_TEXT_STEP_X_FLOAT: text_step_x_fixed_reg <= flt2fix(pwdata, 6'd`FRAC_TEX); // [R7]
            `OFS_RECIPW_STEP_X_FIXED: recipw_step_x_fixed_reg <= pwdata; // [R5]
            `OFS_RECIPW_STEP_X_FLOAT: recipw_step_x_fixed_reg <= flt2fix(pwdata, 6'd`FRAC_RECIPW); // [R7]
            default: depth_step_x_fixed_reg <= depth_step_x_fixed_reg;
         endcase
      end
   end

   // Y gradients of depth, texture and reciprocal W
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         depth_step_y_fixed_reg <= `GRAD_RESET;
         texs_step_y_fixed_reg <= `GRAD_RESET;
         text_step_y_fixed_reg <= `GRAD_RESET;
         recipw_step_y_fixed_reg <= `GRAD_RESET;
      end else if (wr) begin
         case (paddr)
            `OFS_DEPTH_STEP_Y_FIXED: depth_step_y_fixed_reg <= pwdata; // [R3]
            `OFS_DEPTH_STEP_Y_FLOAT: depth_step_y_fixed_reg <= flt2fix(pwdata, 6'd`FRAC_DEPTH); // [R7]
            `OFS_TEXS_STEP_Y_FIXED: texs_step_y_fixed_reg <= pwdata; // [R4]
            `OFS_TEXT_STEP_Y_FIXED: text_step_y_fixed_reg <= pwdata; // [R4]
            `OFS_TEXS_STEP_Y_FLOAT: texs_step_y_fixed_reg <= flt2fix(pwdata, 6'd`FRAC_TEX); // [R7]
            `OFS_TEXT_STEP_Y_FLOAT: text_step_y_fixed_reg <= flt2fix(pwdata, 6'd`FRAC_TEX); // [R7]
            `OFS_RECIPW_STEP_Y_FIXED: recipw_step_y_fixed_reg <= pwdata; // [R5]
            `OFS_RECIPW_STEP_Y_FLOAT: recipw_step_y_fixed_reg <= flt2fix(pwdata, 6'd`FRAC_RECIPW); // [R7]
            default: depth_step_y_fixed_reg <= depth_step_y_fixed_reg;
         endcase
      end
   end

   // Colour Y gradients; float saturation is at 32 bits, then truncated
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         red_step_y_fixed_reg <= 24'h00_0000;
         green_step_y_fixed_reg <= 24'h00_0000;
         blue_step_y_fixed_reg <= 24'h00_0000;
         alpha_step_y_fixed_reg <= 24'h00_0000;
      end else if (wr) begin
         case (paddr)
            `OFS_RED_STEP_Y_FIXED: red_step_y_fixed_reg <= pwdata[`COLOR_MSB:0]; // [R6]
            `OFS_GREEN_STEP_Y_FIXED: green_step_y_fixed_reg <= pwdata[`COLOR_MSB:0]; // [R6]
            `OFS_BLUE_STEP_Y_FIXED: blue_step_y_fixed_reg <= pwdata[`COLOR_MSB:0]; // [R6]
            `OFS_ALPHA_STEP_Y_FIXED: alpha_step_y_fixed_reg <= pwdata[`COLOR_MSB:0]; // [R6]
            `OFS_RED_STEP_Y_FLOAT: red_step_y_fixed_reg <= c_fix[`COLOR_MSB:0]; // [R7]
            `OFS_GREEN_STEP_Y_FLOAT: green_step_y_fixed_reg <= c_fix[`COLOR_MSB:0]; // [R7]
            `OFS_BLUE_STEP_Y_FLOAT: blue_step_y_fixed_reg <= c_fix[`COLOR_MSB:0]; // [R7]
            `OFS_ALPHA_STEP_Y_FLOAT: alpha_step_y_fixed_reg <= c_fix[`COLOR_MSB:0]; // [R7]
            default: red_step_y_fixed_reg <= red_step_y_fixed_reg;
         endcase
      end
   end

   // Accumulator select
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_sel_reg <= 3'h0;
      end else if (wr && paddr == `OFS_ACC_SELECT) begin
         acc_sel_reg <= pwdata[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Draw command and step sources
   wire cmd_wr = wr && (paddr == `OFS_DRAW_TRIANGLE_FIXED ||
                        paddr == `OFS_DRAW_TRIANGLE_FLOAT);
   wire sw_step = wr && (paddr == `OFS_STEP_CONTROL);
   wire do_x = hw_x | (sw_step & pwdata[`STEP_X_BIT]);
   wire do_y = hw_y | (sw_step & pwdata[`STEP_Y_BIT]);
   wire neg = sw_step ? pwdata[`STEP_NEG_BIT] : hw_neg;
   wire done = hw_done | (sw_step & pwdata[`STEP_DONE_BIT]);

   // One-cycle start pulse
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         draw_start <= 1'b0;
      end else begin
         draw_start <= cmd_wr; // [R9]
      end
   end

   // Orientation and busy; a new command wins over a same-cycle done
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         orient_cw <= 1'b0;
         busy <= 1'b0;
      end else begin
         if (cmd_wr) begin
            // Only the sign is kept, remaining bits are dropped
            orient_cw <= pwdata[`ORIENT_BIT]; // [R11] [R12]
            busy <= 1'b1; // [R9]
         end else if (done) begin
            busy <= 1'b0;
         end
      end
   end

   // Vertex is 12.4 two's complement, latched at draw start
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_vertex <= 32'h0000_0000;
      end else if (cmd_wr) begin
         start_vertex <= {vertex_y, vertex_x}; // [R17]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Accumulators; cleared at start since start values live elsewhere
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         depth_acc <= 32'h0000_0000;
         texs_acc <= 32'h0000_0000;
         text_acc <= 32'h0000_0000;
         recipw_acc <= 32'h0000_0000;
      end else if (cmd_wr) begin
         depth_acc <= 32'h0000_0000;
         texs_acc <= 32'h0000_0000;
         text_acc <= 32'h0000_0000;
         recipw_acc <= 32'h0000_0000;
      end else if (busy && do_x) begin
         depth_acc <= step_val(depth_acc, depth_step_x_fixed_reg, neg); // [R1]
         texs_acc <= step_val(texs_acc, texs_step_x_fixed_reg, neg); // [R1]
         text_acc <= step_val(text_acc, text_step_x_fixed_reg, neg); // [R1]
         recipw_acc <= step_val(recipw_acc, recipw_step_x_fixed_reg, neg); // [R1]
      end else if (busy && do_y) begin
         depth_acc <= step_val(depth_acc, depth_step_y_fixed_reg, neg); // [R2]
         texs_acc <= step_val(texs_acc, texs_step_y_fixed_reg, neg); // [R2]
         text_acc <= step_val(text_acc, text_step_y_fixed_reg, neg); // [R2]
         recipw_acc <= step_val(recipw_acc, recipw_step_y_fixed_reg, neg); // [R2]
      end
   end

   // Colour accumulators; X steps leave colour alone, its X gradients sit
   // outside this block, and an X step in the same cycle wins over Y
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         red_acc <= 24'h00_0000;
         green_acc <= 24'h00_0000;
         blue_acc <= 24'h00_0000;
         alpha_acc <= 24'h00_0000;
      end else if (cmd_wr) begin
         red_acc <= 24'h00_0000;
         green_acc <= 24'h00_0000;
         blue_acc <= 24'h00_0000;
         alpha_acc <= 24'h00_0000;
      end else if (busy && do_y && !do_x) begin
         red_acc <= step_col(red_acc, red_step_y_fixed_reg, neg); // [R2]
         green_acc <= step_col(green_acc, green_step_y_fixed_reg, neg); // [R2]
         blue_acc <= step_col(blue_acc, blue_step_y_fixed_reg, neg); // [R2]
         alpha_acc <= step_col(alpha_acc, alpha_step_y_fixed_reg, neg); // [R2]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; gradient and command registers are write-only
   reg [31:0] acc_mux;
   // Read data is taken in the setup cycle so it stands through the access
   wire rd_setup = psel & ~penable & ~pwrite;
   always @* begin
      case (acc_sel_reg)
         `ACC_DEPTH: acc_mux = depth_acc;
         `ACC_TEXS: acc_mux = texs_acc;
         `ACC_TEXT: acc_mux = text_acc;
         `ACC_RECIPW: acc_mux = recipw_acc;
         `ACC_RED: acc_mux = {8'h00, red_acc};
         `ACC_GREEN: acc_mux = {8'h00, green_acc};
         `ACC_BLUE: acc_mux = {8'h00, blue_acc};
         default: acc_mux = {8'h00, alpha_acc};
      endcase
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         case (paddr)
            `OFS_RASTER_STATUS: prdata <= {30'h0000_0000, orient_cw, busy};
            `OFS_ACC_SELECT: prdata <= {29'h0000_0000, acc_sel_reg};
            `OFS_ACC_VALUE: prdata <= acc_mux;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
   wire unused_rd = rd;

endmodule
`default_nettype wire

/* tb/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_model (
   // Clock
   input wire logic pclk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr
);
   logic [31:0] rd_q;
   logic err_q;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   ////////////////////////////////////////////////////////////////
   // One transfer at a time, strictly in order: fenced by nature
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // The wait ends once pready is high, or at the bench timeout
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Vertices come sorted by rising Y
   function automatic logic area_neg(input int ax, ay, bx, by, cx, cy);
      return ((ax - bx) * (by - cy) - (bx - cx) * (ay - by)) < 0;
   endfunction
   // Dummy texture word goes to another bus, never to this block
   // Sign always matches the vertices, junk in the low bits
   task automatic draw(input logic [11:0] a, input int ax, ay, bx, by, cx, cy);
      xfer(1'b1, a, {area_neg(ax, ay, bx, by, cx, cy), 31'h0ABC_DEF0});
   endtask
endmodule
`default_nettype wire

/* tb/test_triangle_gradient_setup.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module test_triangle_gradient_setup;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic step_x = 1'b0;
   logic step_y = 1'b0;
   logic step_neg = 1'b0;
   logic raster_done = 1'b0;
   logic [15:0] vertex_x = 16'h0123;
   logic [15:0] vertex_y = 16'hFFF0;
   logic draw_start, orient_cw, busy;
   logic [31:0] depth_acc, texs_acc, text_acc, recipw_acc, start_vertex;
   logic [23:0] red_acc, green_acc, blue_acc, alpha_acc;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;
   always #4 pclk = ~pclk;
   task automatic final_report;
      if (miscompares == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Whole run needs about 115 cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         final_report();
      end
   end
   host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
   triangle_gradient_setup i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .step_x(step_x), .step_y(step_y),
      .step_neg(step_neg), .raster_done(raster_done), .vertex_x(vertex_x),
      .vertex_y(vertex_y), .draw_start(draw_start), .orient_cw(orient_cw), .busy(busy),
      .depth_acc(depth_acc), .texs_acc(texs_acc), .text_acc(text_acc),
      .recipw_acc(recipw_acc), .red_acc(red_acc), .green_acc(green_acc),
      .blue_acc(blue_acc), .alpha_acc(alpha_acc), .start_vertex(start_vertex));
   ////////////////////////////////////////////////////////////////
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d);
      #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      i_host.xfer(1'b0, a, 32'h0000_0000);
      `CHK(i_host.rd_q, e)
   endtask
   // Pin steps pass a 2-flop synchroniser first
   task automatic pin_step(input logic neg, input logic y);
      @(posedge pclk);
      step_neg <= neg;
      step_x <= !y;
      step_y <= y;
      repeat (5) @(posedge pclk);
      step_x <= 1'b0;
      step_y <= 1'b0;
      #1;
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h080, 32'h0000_0000);
      wr(12'h070, 32'h0000_0001);
      `CHK(i_host.err_q, 1'b1)
      rd(12'h0FC, 32'h0000_0000);
      `CHK(i_host.err_q, 1'b1)
      wr(12'h000, 32'h0000_1800);
      rd(12'h000, 32'h0000_0000);
      wr(12'h048, 32'h0004_0000);
      wr(12'h020, 32'hFF00_1000);
      wr(12'h058, 32'h4000_0000);
      wr(12'h04C, 32'h0000_0100);
      wr(12'h024, 32'h0000_0200);
      wr(12'h028, 32'h0000_0300);
      wr(12'h02C, 32'h0000_0400);
      i_host.draw(12'h060, 0, 0, -4, 2, 0, 4);
      #1;
      `CHK(orient_cw, 1'b1)
      `CHK(start_vertex, 32'hFFF0_0123)
      rd(12'h080, 32'h0000_0003);
      wr(12'h084, 32'h0000_0001);
      `CHK(depth_acc, 32'h0000_1800)
      wr(12'h084, 32'h0000_0005);
      wr(12'h084, 32'h0000_0005);
      `CHK(depth_acc, 32'hFFFF_E800)
      wr(12'h084, 32'h0000_0002);
      `CHK(texs_acc, 32'h0004_0000)
      `CHK(red_acc, 24'h00_1000)
      `CHK(recipw_acc, 32'h4000_0000)
      `CHK(text_acc, 32'h0000_0100)
      `CHK(green_acc, 24'h00_0200)
      `CHK(blue_acc, 24'h00_0300)
      `CHK(alpha_acc, 24'h00_0400)
      wr(12'h088, 32'h0000_0001);
      rd(12'h08C, 32'h0004_0000);
      wr(12'h084, 32'h0000_0006);
      `CHK(red_acc, 24'h00_0000)
      wr(12'h004, 32'h4000_0000);
      wr(12'h01C, 32'h3F00_0000);
      wr(12'h030, 32'hBF80_0000);
      i_host.draw(12'h064, 0, 0, 4, 2, 0, 4);
      #1;
      `CHK(orient_cw, 1'b0)
      `CHK(depth_acc, 32'h0000_0000)
      wr(12'h084, 32'h0000_0001);
      `CHK(depth_acc, 32'h0000_2000)
      `CHK(recipw_acc, 32'h2000_0000)
      wr(12'h084, 32'h0000_0002);
      `CHK(red_acc, 24'hFF_F000)
      `CHK(texs_acc, 32'h0004_0000)
      wr(12'h084, 32'h0000_0008);
      rd(12'h080, 32'h0000_0000);
      wr(12'h084, 32'h0000_0001);
      `CHK(depth_acc, 32'h0000_2000)
      i_host.draw(12'h060, 0, 0, -4, 2, 0, 4);
      pin_step(1'b0, 1'b0);
      `CHK(depth_acc, 32'h0000_2000)
      pin_step(1'b1, 1'b1);
      `CHK(red_acc, 24'h00_1000)
      raster_done <= 1'b1;
      repeat (5) @(posedge pclk);
      raster_done <= 1'b0;
      rd(12'h080, 32'h0000_0002);
      final_report();
   end
endmodule
`default_nettype wire

/* tb/triangle_gradient_setup_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module triangle_gradient_setup_properties (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Raster side
   input wire logic [15:0] vertex_x,
   input wire logic [15:0] vertex_y,
   input wire logic draw_start,
   input wire logic orient_cw,
   input wire logic busy,
   input wire logic [31:0] depth_acc,
   input wire logic [31:0] start_vertex
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc_c = psel && penable;
   wire cmd_w = acc_c && pwrite && (paddr == 12'h060 || paddr == 12'h064);
   wire ctl_w = acc_c && pwrite && paddr == 12'h084;
   wire mapped = paddr <= 12'h064 || (paddr >= 12'h080 && paddr <= 12'h08C);
   sequence s_cmd;
      cmd_w;
   endsequence
   sequence s_idle_step;
      ctl_w && (pwdata[0] || pwdata[1]) && !busy;
   endsequence
   sequence s_done;
      ctl_w && pwdata[3];
   endsequence
   // Zero wait states
   AST_PREADY: assert property (pready) else $error("pready low");
   AST_DRAW_PULSE: assert property (s_cmd |=> draw_start) else $error("no draw");
   AST_DRAW_CAUSE: assert property ($rose(draw_start) |-> $past(cmd_w))
      else $error("stray draw");
   AST_BUSY: assert property (s_cmd |=> busy) else $error("not busy");
   AST_ORIENT: assert property (s_cmd |=> orient_cw == $past(pwdata[31]))
      else $error("bad orientation");
   AST_CLEAR: assert property (s_cmd |=> depth_acc == 32'h0000_0000)
      else $error("acc not cleared");
   AST_VERTEX: assert property (s_cmd |=> start_vertex == {$past(vertex_y), $past(vertex_x)})
      else $error("bad vertex");
   // Unaligned handling left open, so only aligned addresses judged
   AST_SLVERR: assert property (acc_c && paddr[1:0] == 2'b00 |-> pslverr == !mapped)
      else $error("bad pslverr");
   AST_IDLE_STEP: assert property (s_idle_step |=> $stable(depth_acc))
      else $error("idle step moved acc");
   AST_DONE: assert property (s_done |=> !busy) else $error("done ignored");
endmodule
bind triangle_gradient_setup triangle_gradient_setup_properties i_props (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .vertex_x, .vertex_y,
   .draw_start, .orient_cw, .busy, .depth_acc, .start_vertex);
`default_nettype wire
